// *** hw/jri_cfg.svh ***
`ifndef JRI_CFG_SVH
`define JRI_CFG_SVH

// ****************************************************************
// Constants of the RAM initialisation interface
// ****************************************************************

// Width of the instruction value seen from the user JTAG macro.
`define JRI_IR_W            8
// Opcode that starts data initialisation of the RAM blocks.
`define JRI_INIT_OPCODE     8'h22
// Opcode that routes the shifted word into the write-address register.
`define JRI_ADDR_OPCODE     8'h24
// First of the per-block opcodes; block i answers to base plus i.
`define JRI_BLK_OPCODE_BASE 8'h30
// Reset value of the address counter: the first word lands here.
`define JRI_ADDR_RST        0
// Reset position of the ring counter: the first block is selected.
`define JRI_RING_RST_BIT    0
// Number of flip-flops in every synchroniser.
`define JRI_SYNC_STAGES     2

`endif

// *** hw/jri_pkg.sv ***
// ****************************************************************
// Types shared by the RAM initialisation interface
// ****************************************************************
package jri_pkg;

    // Core-side write sequencer states, Gray coded along the path.
    typedef enum logic [1:0] {
        JRI_IDLE  = 2'b00,
        JRI_ARMED = 2'b01,
        JRI_WRITE = 2'b11
    } jri_state_e;

    // How the block enables are chosen.
    typedef enum logic [1:0] {
        JRI_SEL_RING      = 2'b00,
        JRI_SEL_OPCODE    = 2'b01,
        JRI_SEL_BROADCAST = 2'b10
    } jri_sel_mode_e;

endpackage : jri_pkg

// *** hw/jri_sync.sv ***
`timescale 1ns/100ps
`include "jri_cfg.svh"

// ****************************************************************
// Two flip-flop level synchroniser, one lane per bit
// ****************************************************************
module jri_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_in,
    input  wire logic             rst_in,
    input  wire logic             clk_en_in,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    // Both stages travel together; only the second stage is read outside.
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] safe;
    } jri_sync_s;

    jri_sync_s s_r;    // Registered stages.
    jri_sync_s s_nxt;  // Next value of the stages.

    // The first stage feeds the second stage and nothing else.
    always_comb begin
        s_nxt = s_r;
        if (clk_en_in) begin
            s_nxt.meta = async_in;
            s_nxt.safe = s_r.meta;
        end
    end

    // Stages clear to zero under reset.
    always_ff @(posedge clk_in or posedge rst_in) begin
        if (rst_in) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign sync_out = s_r.safe;

endmodule : jri_sync

// *** hw/jri_sipo.sv ***
`timescale 1ns/100ps
`include "jri_cfg.svh"

// ****************************************************************
// Serial-in parallel-out register on the JTAG data-register clock
// ****************************************************************
module jri_sipo #(
    parameter int WIDTH = 4
) (
    input  wire logic             link_clk_in,
    input  wire logic             rst_in,
    input  wire logic             shift_en_in,
    input  wire logic             serial_in,
    output logic      [WIDTH-1:0] word_out,
    output logic                  word_tgl_out,
    output logic                  serial_out
);

    localparam int CW = $clog2(WIDTH + 1);

    // Shift chain, bit count, completed word and its event toggle.
    typedef struct packed {
        logic [WIDTH-1:0] chain;
        logic [CW-1:0]    cnt;
        logic [WIDTH-1:0] hold;
        logic             tgl;
    } jri_sipo_s;

    jri_sipo_s s_r;    // Registered state.
    jri_sipo_s s_nxt;  // Next state.

    // Bits enter at the top so the first bit shifted ends as bit zero.
    // The hold register only changes once a whole word is in, so the
    // core side may sample it any time after it sees the toggle move.
    always_comb begin
        s_nxt = s_r;
        if (shift_en_in) begin
            s_nxt.chain = {serial_in, s_r.chain[WIDTH-1:1]};
            if (s_r.cnt == CW'(WIDTH - 1)) begin
                s_nxt.hold = {serial_in, s_r.chain[WIDTH-1:1]};
                s_nxt.tgl  = ~s_r.tgl;
                s_nxt.cnt  = '0;
            end else begin
                s_nxt.cnt = CW'(s_r.cnt + 1'b1);
            end
        end else begin
            // A partial word is dropped when shifting stops.
            s_nxt.cnt = '0;
        end
    end

    // Register the state on the link clock.
    always_ff @(posedge link_clk_in or posedge rst_in) begin
        if (rst_in) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign word_out     = s_r.hold;
    assign word_tgl_out = s_r.tgl;
    assign serial_out   = s_r.chain[0];

endmodule : jri_sipo

// *** hw/jri_top.sv ***
`timescale 1ns/100ps
`include "jri_cfg.svh"


// ****************************************************************
// JTAG-driven RAM initialisation interface
// ****************************************************************
module jri_top
    import jri_pkg::*;
#(
    parameter int            DATA_W      = 4,
    parameter int            ADDR_W      = 2,
    parameter int            NBLK        = 2,
    parameter jri_sel_mode_e SEL_MODE    = JRI_SEL_RING,
    parameter bit            ADDR_LOAD   = 1'b1,
    parameter bit            WCLK_INVERT = 1'b1
) (
    input  wire logic                 core_clk_in,
    input  wire logic                 sys_rst_in,
    input  wire logic                 core_clk_en_in,
    input  wire logic                 user_dr_clock_in,
    input  wire logic                 user_serial_data_in,
    input  wire logic                 dr_shift_state_flag_in,
    input  wire logic                 dr_update_state_flag_in,
    input  wire logic [`JRI_IR_W-1:0] user_instruction_value_in,
    input  wire logic                 jtag_reset_n_in,
    input  wire logic [NBLK-1:0]      user_wen_in,
    input  wire logic [ADDR_W-1:0]    user_addr_in,
    input  wire logic [DATA_W-1:0]    user_data_in,
    output logic                      user_serial_data_out,
    output logic                      wr_clk_out,
    output logic [ADDR_W-1:0]         wr_addr_out,
    output logic [DATA_W-1:0]         wr_data_out,
    output logic [NBLK-1:0]           block_sel_out,
    output logic [NBLK-1:0]           block_wen_out,
    output logic                      init_active_out
);

    localparam int SW = `JRI_IR_W + 4;  // Width of the synchronised bundle.

    // ****************************************************************
    // Link domain: shift registers on the data-register clock
    // ****************************************************************

    logic              ir_is_addr;   // Address opcode seen in the link domain.
    logic              data_shift;   // Shift enable of the data register.
    logic              addr_shift;   // Shift enable of the address register.
    logic [DATA_W-1:0] data_hold;    // Last complete data word.
    logic              data_tgl;     // Flips once per complete data word.
    logic [ADDR_W-1:0] addr_hold;    // Last complete address word.
    logic              addr_tgl;     // Flips once per complete address word.
    logic              addr_sdo;     // Unused serial tail of the address chain.

    // The instruction value and flags come from the macro on the JTAG
    // clock itself, so the link logic may read them directly.
    assign ir_is_addr = ADDR_LOAD && (user_instruction_value_in == `JRI_ADDR_OPCODE);
    assign data_shift = dr_shift_state_flag_in & ~ir_is_addr;
    assign addr_shift = dr_shift_state_flag_in & ir_is_addr;

    jri_sipo #(
        .WIDTH        (DATA_W)
    ) u_data_sipo (
        .link_clk_in  (user_dr_clock_in),
        .rst_in       (sys_rst_in),
        .shift_en_in  (data_shift),
        .serial_in    (user_serial_data_in),
        .word_out     (data_hold),
        .word_tgl_out (data_tgl),
        .serial_out   (user_serial_data_out)
    );

    jri_sipo #(
        .WIDTH        (ADDR_W)
    ) u_addr_sipo (
        .link_clk_in  (user_dr_clock_in),
        .rst_in       (sys_rst_in),
        .shift_en_in  (addr_shift),
        .serial_in    (user_serial_data_in),
        .word_out     (addr_hold),
        .word_tgl_out (addr_tgl),
        .serial_out   (addr_sdo)
    );

    // ****************************************************************
    // Crossing into the core clock
    // ****************************************************************

    logic [SW-1:0]          sync_q;    // Synchronised bundle.
    logic [`JRI_IR_W-1:0]   ir_s;      // Instruction value, core side.
    logic                   upd_s;     // Update flag, core side.
    logic                   jrst_n_s;  // JTAG reset, core side, active low.
    logic                   dtgl_s;    // Data word toggle, core side.
    logic                   atgl_s;    // Address word toggle, core side.

    // The instruction value, update flag, JTAG reset and each word toggle pass two flip-flops.
    // The held words themselves are not synchronised: they stay still
    // for a whole word time after their toggle moves.
    jri_sync #(
        .WIDTH     (SW)
    ) u_sync (
        .clk_in    (core_clk_in),
        .rst_in    (sys_rst_in),
        .clk_en_in (core_clk_en_in),
        .async_in  ({user_instruction_value_in, dr_update_state_flag_in,
                     jtag_reset_n_in, data_tgl, addr_tgl}),
        .sync_out  (sync_q)
    );

    assign {ir_s, upd_s, jrst_n_s, dtgl_s, atgl_s} = sync_q;

    // ****************************************************************
    // Core domain: opcode compare, address and block sequencing
    // ****************************************************************

    logic [NBLK-1:0] blk_match;  // Per-block opcode hits.

    for (genvar gi = 0; gi < NBLK; gi++) begin : g_blk
        assign blk_match[gi] = (ir_s == `JRI_IR_W'(`JRI_BLK_OPCODE_BASE + gi));
    end

    // All core state in one record.
    typedef struct packed {
        jri_state_e        st;
        logic              upd_prev;
        logic              dtgl_seen;
        logic              atgl_seen;
        logic              word_rdy;
        logic [ADDR_W-1:0] addr_cnt;
        logic [NBLK-1:0]   ring;
        logic [DATA_W-1:0] wdata;
        logic [ADDR_W-1:0] waddr;
        logic [NBLK-1:0]   wsel;
        logic [NBLK-1:0]   wen;
        logic              wclk;
        logic              active;
    } jri_core_s;

    jri_core_s s_r;    // Registered core state.
    jri_core_s s_nxt;  // Next core state.

    logic              upd_rise;   // Update state just entered.
    logic              upd_fall;   // Update state just left.
    logic              data_new;   // A fresh data word has crossed.
    logic              addr_new;   // A fresh address word has crossed.
    logic              have_word;  // A complete word is waiting.
    logic              act;        // Initialisation opcode currently loaded.
    logic              present;    // This edge puts a word on the RAM ports.
    logic [NBLK-1:0]   sel_vec;    // Block selection for the present mode.
    logic [NBLK-1:0]   ring_rot;   // Ring counter after one step.

    // Edge and event detection reads only second-stage outputs.
    // update rise ends word.
    assign upd_rise  = upd_s & ~s_r.upd_prev;
    assign upd_fall  = ~upd_s & s_r.upd_prev;
    assign data_new  = dtgl_s ^ s_r.dtgl_seen;
    assign addr_new  = ADDR_LOAD && (atgl_s ^ s_r.atgl_seen);
    assign have_word = s_r.word_rdy | data_new;
    assign ring_rot  = {s_r.ring[NBLK-2:0], s_r.ring[NBLK-1]};

    // Selection and activity depend on the mode chosen at build time.
    always_comb begin
        case (SEL_MODE)
            JRI_SEL_RING: begin
                act     = (ir_s == `JRI_INIT_OPCODE);
                sel_vec = s_r.ring;
            end
            JRI_SEL_OPCODE: begin
                act     = |blk_match;
                sel_vec = blk_match;
            end
            JRI_SEL_BROADCAST: begin
                act     = (ir_s == `JRI_INIT_OPCODE);
                sel_vec = '1;
            end
            default: begin
                act     = 1'b0;
                sel_vec = '0;
            end
        endcase
    end

    assign present = (s_r.st == JRI_ARMED) && act && upd_rise && have_word && jrst_n_s;

    // Next core state. Everything holds while the clock enable is low.
    always_comb begin
        s_nxt = s_r;
        if (core_clk_en_in) begin
            s_nxt.upd_prev  = upd_s;
            s_nxt.dtgl_seen = dtgl_s;
            s_nxt.atgl_seen = atgl_s;
            s_nxt.active    = act;
            s_nxt.wsel      = (s_r.st == JRI_WRITE) ? s_r.wsel : sel_vec;
            s_nxt.wclk      = WCLK_INVERT ? ~upd_s : upd_s;
            // complete word only; a new word beats a consume.
            s_nxt.word_rdy  = data_new | (s_r.word_rdy & ~present);

            case (s_r.st)
                JRI_IDLE: begin
                    s_nxt.wdata = user_data_in;
                    s_nxt.waddr = user_addr_in;
                    s_nxt.wen   = user_wen_in;
                    if (act) begin
                        s_nxt.st  = JRI_ARMED;
                        s_nxt.wen = '0;
                    end
                end
                JRI_ARMED: begin
                    if (!act) begin
                        s_nxt.st = JRI_IDLE;
                    end else if (present) begin
                        s_nxt.st    = JRI_WRITE;
                        s_nxt.wdata = data_hold;
                        s_nxt.waddr = s_r.addr_cnt;
                        s_nxt.wen   = sel_vec;
                        s_nxt.addr_cnt = ADDR_W'(s_r.addr_cnt + 1'b1);
                        if ((SEL_MODE == JRI_SEL_RING) && (&s_r.addr_cnt)) begin
                            s_nxt.ring = ring_rot;
                        end
                    end
                end
                // outputs steady until the write clock edge.
                JRI_WRITE: begin
                    if (!act) begin
                        s_nxt.st  = JRI_IDLE;
                        s_nxt.wen = '0;
                    end else if (upd_fall) begin
                        s_nxt.st = JRI_ARMED;
                    end
                end
                default: begin
                    s_nxt.st  = JRI_IDLE;
                    s_nxt.wen = '0;
                end
            endcase

            if (addr_new) begin
                s_nxt.addr_cnt = addr_hold;
            end
            if (!jrst_n_s) begin
                s_nxt.st       = JRI_IDLE;
                s_nxt.addr_cnt = ADDR_W'(`JRI_ADDR_RST);
                s_nxt.ring     = NBLK'(1) << `JRI_RING_RST_BIT;
                s_nxt.word_rdy = 1'b0;
                s_nxt.wen      = '0;
            end
        end
    end

    // Register the core state. The write clock idles high after reset
    // so a RAM clocked on its rising edge sees no spurious edge.
    always_ff @(posedge core_clk_in or posedge sys_rst_in) begin
        if (sys_rst_in) begin
            s_r          <= '0;
            s_r.st       <= JRI_IDLE;
            s_r.ring     <= NBLK'(1) << `JRI_RING_RST_BIT;
            s_r.addr_cnt <= ADDR_W'(`JRI_ADDR_RST);
            s_r.wclk     <= WCLK_INVERT;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign wr_clk_out      = s_r.wclk;
    assign wr_addr_out     = s_r.waddr;
    assign wr_data_out     = s_r.wdata;
    assign block_sel_out   = s_r.wsel;
    assign block_wen_out   = s_r.wen;
    assign init_active_out = s_r.active;

    // ****************************************************************
    // Checks on the core-side sequencing
    // ****************************************************************
    default clocking cb @(posedge core_clk_in); endclocking
    default disable iff (sys_rst_in || !core_clk_en_in);
    // Write clock sits at its active-low phase for the whole write.
    a_wclk_low_write: assert property (
        (s_r.st == JRI_WRITE) |-> (wr_clk_out == !WCLK_INVERT))
        else $error("write clock not low while a word is presented");
    // Nothing on the RAM ports moves inside a write.
    a_ports_hold_write: assert property (
        (s_r.st == JRI_WRITE) && core_clk_en_in ##1 (s_r.st == JRI_WRITE)
        |-> $stable(wr_data_out) && $stable(wr_addr_out) && $stable(block_wen_out))
        else $error("write data or address moved during a write");
    // A presented word carries the counter value and bumps the counter.
    a_addr_sweep_step: assert property (
        present && !addr_new |=> (wr_addr_out == $past(s_r.addr_cnt))
        && (s_r.addr_cnt == ADDR_W'($past(s_r.addr_cnt) + 1'b1)))
        else $error("address counter did not step by one");
    // The ring holds exactly one block.
    a_ring_one_hot: assert property (
        $onehot(s_r.ring))
        else $error("ring counter lost its single token");
    // Ring moves on when the last address of a sweep is presented.
    a_ring_advance: assert property (
        present && (SEL_MODE == JRI_SEL_RING) && (&s_r.addr_cnt)
        |=> (s_r.ring == $past(ring_rot)))
        else $error("ring did not advance after a full sweep");
    // Enables during a write stay inside the selected blocks.
    a_wen_selected: assert property (
        (s_r.st == JRI_WRITE) |-> ((block_wen_out & ~block_sel_out) == '0))
        else $error("write enable outside the selected block");
    // Without the opcode the sequencer leaves the write path next cycle.
    a_opcode_gate: assert property (
        !act |=> (s_r.st == JRI_IDLE))
        else $error("sequencer active without the start opcode");
    // A word that arrives is remembered, even against a consume.
    a_word_set_wins: assert property (
        data_new |=> s_r.word_rdy)
        else $error("arriving data word was lost");
    // A write only starts with a complete word waiting.
    a_write_needs_word: assert property (
        (s_r.st == JRI_ARMED) ##1 (s_r.st == JRI_WRITE) |-> $past(have_word))
        else $error("write started without a complete word");
    // JTAG reset puts the next word at address zero of the first block.
    a_jreset_preset: assert property (
        !jrst_n_s |=> (s_r.addr_cnt == ADDR_W'(`JRI_ADDR_RST))
        && (s_r.ring == (NBLK'(1) << `JRI_RING_RST_BIT)))
        else $error("JTAG reset did not preset counters");
    c_word_written: cover property (present ##[1:20] upd_fall);
    c_ring_wrap: cover property (present && (&s_r.addr_cnt));
    c_addr_loaded: cover property (addr_new);
    c_abort_write: cover property ((s_r.st == JRI_WRITE) ##1 (s_r.st == JRI_IDLE));

endmodule : jri_top

// *** verif/jri_jtag_model.sv ***
`timescale 1ns/100ps
// ****************************************************************
// Behavioural user JTAG macro driving the loader's link side
// ****************************************************************
module jri_jtag_model (
    output logic       tck_out,
    output logic       tdi_out,
    output logic       shift_out,
    output logic       upd_out,
    output logic [7:0] ir_out,
    output logic       rst_n_out
);
    // Idle values; the data clock stands low outside frames.
    initial begin
        {tck_out, tdi_out, shift_out, upd_out, ir_out, rst_n_out} = 13'h0001;
    end
    // One data clock period, 80 ns long: 40 ns low, then 40 ns high.
    task automatic pulse();
        #40 tck_out = 1'b1;
        #40 tck_out = 1'b0;
    endtask : pulse
    task automatic shift_bits(input logic [7:0] val, input int n);
        #13 shift_out = 1'b1;
        for (int i = 0; i < n; i++) begin
            tdi_out = val[i];
            pulse();
        end
        shift_out = 1'b0;
        // Released line shows the inverse so a stale bit is never reused.
        tdi_out = ~tdi_out;
        pulse();
        pulse();
    endtask : shift_bits
    task automatic upd_set(input logic b);
        upd_out = b;
    endtask : upd_set
    task automatic set_ctl(input logic [7:0] ir, input logic rn);
        ir_out = ir;
        rst_n_out = rn;
    endtask : set_ctl
endmodule : jri_jtag_model

// *** verif/testbench.sv ***
`timescale 1ns/100ps
// ****************************************************************
// Self-checking bench of the JTAG RAM loader
// ****************************************************************
module testbench;
    logic       core_clk_in = 1'b0;
    logic       sys_rst_in  = 1'b1;
    logic       cen         = 1'b1;
    logic [1:0] u_wen = 2'h0;
    logic [1:0] u_addr = 2'h0;
    logic [3:0] u_data = 4'h0;
    logic       tck, tdi, shf, upd, jrst_n, tdo, wclk, act;
    logic [7:0] ir;
    logic [1:0] waddr, bsel, bwen;
    logic [3:0] wdata;
    int         err_total = 0;
    int         check_count = 0;
    always #20 core_clk_in = ~core_clk_in;
    jri_jtag_model u_jtag (.tck_out(tck), .tdi_out(tdi), .shift_out(shf), .upd_out(upd),
        .ir_out(ir), .rst_n_out(jrst_n));
    jri_top dut (.core_clk_in(core_clk_in), .sys_rst_in(sys_rst_in), .core_clk_en_in(cen),
        .user_dr_clock_in(tck), .user_serial_data_in(tdi), .dr_shift_state_flag_in(shf),
        .dr_update_state_flag_in(upd), .user_instruction_value_in(ir), .jtag_reset_n_in(jrst_n),
        .user_wen_in(u_wen), .user_addr_in(u_addr), .user_data_in(u_data),
        .user_serial_data_out(tdo), .wr_clk_out(wclk), .wr_addr_out(waddr),
        .wr_data_out(wdata), .block_sel_out(bsel), .block_wen_out(bwen), .init_active_out(act));
    // Compare one value and count it.
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge core_clk_in);
    endtask : cyc
    // Shift a word, pulse update and judge what reaches the RAM ports.
    task automatic write_word(input logic [3:0] w, input logic [1:0] a, input logic [1:0] s);
        u_jtag.shift_bits(8'(w), 4);
        cyc(2);
        u_jtag.upd_set(1'b1);
        cyc(6);
        chk(8'(wclk), 8'h00);
        chk(8'(wdata), 8'(w));
        chk(8'(waddr), 8'(a));
        chk(8'(bsel), 8'(s));
        chk(8'(bwen), 8'(s));
        chk(8'(tdo), 8'(w[0]));
        u_jtag.upd_set(1'b0);
        cyc(5);
        chk(8'(wclk), 8'h01);
    endtask : write_word
    // Idle path follows the user logic inputs.
    task automatic t_idle();
        u_addr <= 2'h1;
        u_data <= 4'hA;
        u_wen  <= 2'h2;
        cyc(3);
        chk({wdata, 2'h0, waddr}, 8'hA1);
        chk(8'(bwen), 8'h02);
        // Clock enable low freezes the registered user path.
        cen    <= 1'b0;
        u_data <= 4'h5;
        cyc(3);
        chk(8'(wdata), 8'h0A);
        cen    <= 1'b1;
        cyc(2);
        chk(8'(wdata), 8'h05);
    endtask : t_idle
    // Full sweep of both blocks and a wrap of the ring.
    task automatic t_sweep();
        u_jtag.set_ctl(8'h22, 1'b1);
        cyc(4);
        chk(8'(act), 8'h01);
        for (int i = 0; i < 9; i++) begin
            write_word(4'(i * 5 + 3), 2'(i), ((i / 4) % 2) ? 2'h2 : 2'h1);
        end
    endtask : t_sweep
    // A short word is dropped; the next full word takes the next address.
    task automatic t_partial();
        u_jtag.shift_bits(8'h05, 3);
        cyc(2);
        u_jtag.upd_set(1'b1);
        cyc(6);
        chk({wdata, 2'h0, waddr}, 8'hB0);
        u_jtag.upd_set(1'b0);
        cyc(5);
        write_word(4'hC, 2'h1, 2'h1);
    endtask : t_partial
    // Address loaded over the second opcode, then mismatch and reset.
    task automatic t_addr_rst();
        u_jtag.set_ctl(8'h24, 1'b1);
        cyc(4);
        u_jtag.shift_bits(8'h03, 2);
        cyc(4);
        u_jtag.set_ctl(8'h22, 1'b1);
        cyc(4);
        write_word(4'h6, 2'h3, 2'h1);
        u_jtag.set_ctl(8'h00, 1'b1);
        cyc(5);
        chk({act, 5'h00, bwen}, 8'h02);
        u_jtag.set_ctl(8'h22, 1'b0);
        cyc(5);
        u_jtag.set_ctl(8'h22, 1'b1);
        cyc(4);
        write_word(4'hF, 2'h0, 2'h1);
    endtask : t_addr_rst
    task automatic end_sim();
        $display("checks=%0d mismatches=%0d", check_count, err_total);
        if (err_total == 0 && check_count > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : end_sim
    // Watchdog: the whole run needs well under 400 us.
    initial begin
        #400000;
        err_total++;
        end_sim();
    end
    // Main sequence.
    initial begin
        u_jtag.pulse();
        cyc(9);
        chk({wclk, act, 2'h0, bwen, bsel}, 8'h80);
        sys_rst_in <= 1'b0;
        cyc(3);
        t_idle();
        t_sweep();
        t_partial();
        t_addr_rst();
        end_sim();
    end
endmodule : testbench
